// File: pwm_defines.svh
// constants for the six-channel pulse width modulator
`ifndef PWM_DEFINES_SVH
`define PWM_DEFINES_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define PWM_OFS_CTRL 12'h000
`define PWM_OFS_UPDATE 12'h004
`define PWM_OFS_STATUS 12'h008
`define PWM_OFS_CH_BASE 12'h010
`define PWM_OFS_CH_STRIDE 12'h008
`define PWM_OFS_CH_LAST 12'h03C

// ************************************************************
// field positions and widths
// ************************************************************
`define PWM_NUM_CH 6
`define PWM_DIV_W 16
`define PWM_CTRL_CLKSEL_BIT 0
`define PWM_CHCFG_EN_BIT 0
`define PWM_CHCFG_SINGLE_BIT 1
`define PWM_CHCFG_INV_BIT 2
`define PWM_CHCFG_SYNC_BIT 3
`define PWM_CH_HIGH_LSB 0
`define PWM_CH_LOW_LSB 16
`define PWM_STATUS_BUSY_LSB 0
`define PWM_STATUS_PEND_LSB 8

// ************************************************************
// reset values
// ************************************************************
`define PWM_RST_DIV 16'h0001
`define PWM_RST_CFG 4'h0
`define PWM_CNT_ONE 16'h0001

`endif

// File: pwm_pkg.sv
// types shared by the pulse width modulator files
`default_nettype none
package pwm_pkg;
    // channel phase state
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_HIGH = 2'b01,
        PH_LOW = 2'b10
    } phase_type;
endpackage : pwm_pkg
`default_nettype wire

// File: pwm_channel.sv
// one pulse width modulator channel: high/low counter and output stage
`include "pwm_defines.svh"
`default_nettype none
module pwm_channel (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // counting tick from the selected clock
    input wire logic tick,
    // active settings
    input wire logic enable,
    input wire logic single,
    input wire logic [`PWM_DIV_W-1:0] high_div,
    input wire logic [`PWM_DIV_W-1:0] low_div,
    // channel state
    output logic wave,
    output logic busy
);
    pwm_pkg::phase_type phase;
    logic [`PWM_DIV_W-1:0] count;

    // divider of zero is treated as one so a phase never vanishes
    function automatic logic [`PWM_DIV_W-1:0] load_of(input logic [`PWM_DIV_W-1:0] d);
        load_of = (d == '0) ? `PWM_CNT_ONE : d;
    endfunction : load_of

    // high phase, then low phase, then repeat
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= pwm_pkg::PH_IDLE;
            count <= `PWM_CNT_ONE;
        end else if (ce) begin
            if (!enable) begin
                phase <= pwm_pkg::PH_IDLE;
            end else if (tick) begin
                case (phase)
                    pwm_pkg::PH_IDLE: begin
                        phase <= pwm_pkg::PH_HIGH;
                        count <= load_of(high_div);
                    end
                    pwm_pkg::PH_HIGH: begin
                        if (count == `PWM_CNT_ONE) begin
                            phase <= pwm_pkg::PH_LOW;
                            count <= load_of(low_div);
                        end else begin
                            count <= count - `PWM_CNT_ONE;
                        end
                    end
                    pwm_pkg::PH_LOW: begin
                        if (count != `PWM_CNT_ONE) begin
                            count <= count - `PWM_CNT_ONE;
                        // single pulse parks low until re-enabled
                        end else if (single) begin
                            phase <= pwm_pkg::PH_LOW;
                            count <= `PWM_CNT_ONE;
                        end else begin
                            phase <= pwm_pkg::PH_HIGH;
                            count <= load_of(high_div);
                        end
                    end
                    default: begin
                        phase <= pwm_pkg::PH_IDLE;
                    end
                endcase
            end
        end
    end

    // single pulse is finished once the low phase expires; busy drops
    logic done;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done <= 1'b0;
        end else if (ce) begin
            if (!enable) begin
                done <= 1'b0;
            end else if (tick && single && phase == pwm_pkg::PH_LOW && count == `PWM_CNT_ONE) begin
                done <= 1'b1;
            end
        end
    end

    assign wave = (phase == pwm_pkg::PH_HIGH);
    assign busy = (phase != pwm_pkg::PH_IDLE) && !done;
endmodule : pwm_channel
`default_nettype wire

// File: pwm_clock_tick.sv
// counting-clock selector: picks the fast or crystal-rate tick
`include "pwm_defines.svh"
`default_nettype none
module pwm_clock_tick (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // candidate clock enables, synchronous to hclk
    input wire logic fast_tick_in,
    input wire logic xtal_tick_in,
    // selection and result
    input wire logic sel_xtal,
    output logic tick
);
    // registered so a selection change never yields a runt tick
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick <= 1'b0;
        end else if (ce) begin
            // fast pll tick or crystal-rate tick
            tick <= sel_xtal ? xtal_tick_in : fast_tick_in;
        end
    end
endmodule : pwm_clock_tick
`default_nettype wire

// File: pwm_top.sv
// six-channel pulse width modulator with an ahb-lite register slave
`include "pwm_defines.svh"
`default_nettype none
module pwm_top (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // counting clock sources as enables
    input wire logic fast_tick_in,
    input wire logic xtal_tick_in,
    // pulse outputs
    output logic [`PWM_NUM_CH-1:0] pwm_out
);
    localparam int NCH = `PWM_NUM_CH;
    localparam int DW = `PWM_DIV_W;

    // ************************************************************
    // bus address phase capture
    // ************************************************************
    logic wr_pend;
    logic [11:0] wr_addr;
    logic rd_go;

    // index of the channel register addressed, or NCH when none
    // channel words sit in pairs: divider at the even word, config at the odd
    function automatic logic [3:0] ch_index(input logic [11:0] a);
        logic [11:0] rel;
        rel = a - `PWM_OFS_CH_BASE;
        ch_index = 4'(NCH);
        if (a >= `PWM_OFS_CH_BASE && a <= `PWM_OFS_CH_LAST) begin
            ch_index = rel[6:3];
        end
    endfunction : ch_index

    // true for the configuration word of a channel, false for its divider word
    function automatic logic is_cfg_word(input logic [11:0] a);
        is_cfg_word = a[2];
    endfunction : is_cfg_word

    assign rd_go = hsel && hready && htrans[1] && !hwrite;

    // writes are committed in the data phase when hwdata stands
    // limitation: hsize is not checked, every access is taken as a whole word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 12'h000;
        end else if (ce && hready) begin
            wr_pend <= hsel && htrans[1] && hwrite;
            wr_addr <= haddr;
        end
    end

    // zero wait states, always okay
    // trade-off: no wait states, so a read sees a write only after one idle cycle
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ************************************************************
    // software settings (shadow) and active copies
    // ************************************************************
    logic clk_sel_xtal;
    logic [DW-1:0] sh_high [NCH];
    logic [DW-1:0] sh_low [NCH];
    logic [NCH-1:0] sh_en;
    logic [NCH-1:0] sh_single;
    logic [NCH-1:0] sh_inv;
    logic [NCH-1:0] sync_grp;
    logic [NCH-1:0] grp_now;
    logic [NCH-1:0] pending;
    logic [DW-1:0] act_high [NCH];
    logic [DW-1:0] act_low [NCH];
    logic [NCH-1:0] act_en;
    logic [NCH-1:0] act_single;
    logic [NCH-1:0] act_inv;
    logic [NCH-1:0] busy;
    logic [NCH-1:0] wave;
    logic [NCH-1:0] upd_req;
    logic [NCH-1:0] wr_ch;
    logic [3:0] wr_idx;
    logic wr_upd;

    assign wr_idx = ch_index(wr_addr);
    assign wr_upd = wr_pend && wr_addr == `PWM_OFS_UPDATE;

    // one-hot decode of the channel written this cycle
    // the index is unique, so at most one channel matches
    always_comb begin
        wr_ch = '0;
        for (int i = 0; i < NCH; i++) begin
            wr_ch[i] = wr_pend && wr_idx == 4'(i);
        end
    end

    // global control: counting clock select
    // crystal-rate tick when set, fast tick otherwise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_sel_xtal <= 1'b0;
        end else if (ce && wr_pend && wr_addr == `PWM_OFS_CTRL) begin
            clk_sel_xtal <= hwdata[`PWM_CTRL_CLKSEL_BIT];
        end
    end

    // independent high and low dividers per channel
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NCH; i++) begin
                sh_high[i] <= `PWM_RST_DIV;
                sh_low[i] <= `PWM_RST_DIV;
            end
            sh_en <= '0;
            sh_single <= '0;
            sh_inv <= '0;
            sync_grp <= '0;
        end else if (ce) begin
            for (int i = 0; i < NCH; i++) begin
                if (wr_ch[i] && !is_cfg_word(wr_addr)) begin
                    sh_high[i] <= hwdata[`PWM_CH_HIGH_LSB +: DW];
                    sh_low[i] <= hwdata[`PWM_CH_LOW_LSB +: DW];
                end
                if (wr_ch[i] && is_cfg_word(wr_addr)) begin
                    sh_en[i] <= hwdata[`PWM_CHCFG_EN_BIT];
                    sh_single[i] <= hwdata[`PWM_CHCFG_SINGLE_BIT];
                    sh_inv[i] <= hwdata[`PWM_CHCFG_INV_BIT];
                    sync_grp[i] <= hwdata[`PWM_CHCFG_SYNC_BIT];
                end
            end
        end
    end

    // a config write carries its own group bit, so a channel that joins
    // a group with this very write already waits for the common update
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            if (wr_ch[i] && is_cfg_word(wr_addr)) begin
                grp_now[i] = hwdata[`PWM_CHCFG_SYNC_BIT];
            end else begin
                grp_now[i] = sync_grp[i];
            end
        end
    end

    // an independent channel applies on its own write, a grouped one
    // waits for an update write that sets its bit, so group members named in one update switch together
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            upd_req[i] = (wr_ch[i] && !grp_now[i]) || (wr_upd && hwdata[i] && sync_grp[i]);
        end
    end

    // pending marks settings written but not yet applied in the group
    // software sees which grouped settings still wait for the update
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pending <= '0;
        end else if (ce) begin
            for (int i = 0; i < NCH; i++) begin
                // a fresh write beats the apply in the same cycle
                if (wr_ch[i] && grp_now[i]) begin
                    pending[i] <= 1'b1;
                end else if (upd_req[i]) begin
                    pending[i] <= 1'b0;
                end
            end
        end
    end

    // the active copy is all that the channel engine sees
    // active copies, loaded one cycle after the request so that the
    // value written in the same cycle is already in the shadow
    logic [NCH-1:0] upd_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            upd_q <= '0;
            for (int i = 0; i < NCH; i++) begin
                act_high[i] <= `PWM_RST_DIV;
                act_low[i] <= `PWM_RST_DIV;
            end
            act_en <= '0;
            act_single <= '0;
            act_inv <= '0;
        end else if (ce) begin
            upd_q <= upd_req;
            for (int i = 0; i < NCH; i++) begin
                if (upd_q[i]) begin
                    act_high[i] <= sh_high[i];
                    act_low[i] <= sh_low[i];
                    act_en[i] <= sh_en[i];
                    act_single[i] <= sh_single[i];
                    act_inv[i] <= sh_inv[i];
                end
            end
        end
    end

    // ************************************************************
    // counting clock and channels
    // ************************************************************
    logic tick;

    pwm_clock_tick u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .fast_tick_in(fast_tick_in),
        .xtal_tick_in(xtal_tick_in),
        .sel_xtal(clk_sel_xtal),
        .tick(tick)
    );

    // six independent channel engines
    // all engines share one tick, so grouped channels start on the same edge
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gen_ch
            pwm_channel u_ch (
                .hclk(hclk),
                .hresetn(hresetn),
                .ce(ce),
                .tick(tick),
                .enable(act_en[g]),
                .single(act_single[g]),
                .high_div(act_high[g]),
                .low_div(act_low[g]),
                .wave(wave[g]),
                .busy(busy[g])
            );
        end
    endgenerate

    // invert only the odd member of each pair, registered output
    // even channels ignore the invert bit, so in a pair only the odd channel can be inverted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_out <= '0;
        end else if (ce) begin
            for (int i = 0; i < NCH; i++) begin
                pwm_out[i] <= wave[i] ^ (act_inv[i] && (i % 2 == 1));
            end
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    logic [31:0] next_hrdata;
    logic [3:0] rd_idx;
    assign rd_idx = ch_index(haddr);

    always_comb begin
        next_hrdata = 32'h0000_0000;
        if (haddr == `PWM_OFS_CTRL) begin
            next_hrdata[`PWM_CTRL_CLKSEL_BIT] = clk_sel_xtal;
        end else if (haddr == `PWM_OFS_STATUS) begin
            // busy stays set until a single pulse has finished
            next_hrdata[`PWM_STATUS_BUSY_LSB +: NCH] = busy;
            next_hrdata[`PWM_STATUS_PEND_LSB +: NCH] = pending;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (rd_idx == 4'(i) && is_cfg_word(haddr)) begin
                    next_hrdata[`PWM_CHCFG_EN_BIT] = sh_en[i];
                    next_hrdata[`PWM_CHCFG_SINGLE_BIT] = sh_single[i];
                    next_hrdata[`PWM_CHCFG_INV_BIT] = sh_inv[i];
                    next_hrdata[`PWM_CHCFG_SYNC_BIT] = sync_grp[i];
                end else if (rd_idx == 4'(i)) begin
                    next_hrdata[`PWM_CH_HIGH_LSB +: DW] = sh_high[i];
                    next_hrdata[`PWM_CH_LOW_LSB +: DW] = sh_low[i];
                end
            end
        end
    end

    // read data captured at the address phase, stands in the data phase
    // limitation: ce low also freezes the read data although the bus stays ready
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ce && rd_go) begin
            hrdata <= next_hrdata;
        end
    end
endmodule : pwm_top
`default_nettype wire

// File: pwm_top_properties.sv
// port-level checks for the six-channel pulse width modulator
`include "pwm_defines.svh"
`default_nettype none
module pwm_top_properties (
    // clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // counting enables and outputs
    input wire logic fast_tick_in,
    input wire logic xtal_tick_in,
    input wire logic [`PWM_NUM_CH-1:0] pwm_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd;
    logic [2:0] quiet;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // read address phase accepted this cycle
    assign rd = ce && hsel && hready && htrans[1] && !hwrite;
    // quiet cycles: no tick, no bus transfer; saturates so it never wraps
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet <= 3'h0;
        end else if (fast_tick_in || xtal_tick_in || (hsel && htrans[1])) begin
            quiet <= 3'h0;
        end else if (quiet != 3'h7) begin
            quiet <= quiet + 3'h1;
        end
    end
    reset_idle_a: assert property ($rose(hresetn) |-> pwm_out == 6'h00)
        else $error("outputs not low after reset");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("slave not ready or not okay");
    unmapped_zero_a: assert property (rd && (haddr == 12'h00C || haddr > 12'h03C) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    update_zero_a: assert property (rd && haddr == 12'h004 |=> hrdata == 32'h0)
        else $error("update register read not zero");
    status_clean_a: assert property (rd && haddr == 12'h008 |=> hrdata[31:14] == 18'h0 && hrdata[7:6] == 2'h0)
        else $error("status reserved bits set");
    rdata_hold_a: assert property (!rd |=> $stable(hrdata))
        else $error("read data moved without a read");
    freeze_out_a: assert property (!ce |=> $stable(pwm_out) && $stable(hrdata))
        else $error("state moved while frozen");
    // quiet for six cycles covers tick pipeline and settings load latency
    quiet_stable_a: assert property (quiet >= 3'h6 |-> $stable(pwm_out))
        else $error("output moved without counting clock");
endmodule : pwm_top_properties
`default_nettype wire

// File: pwm_sink_model.sv
// receiver model: measures run lengths and rising edges on each output
`default_nettype none
module pwm_sink_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // pulse inputs
    input wire logic [5:0] pwm_in,
    // last high and low run in hclk cycles, rising edge count
    output int hi_len [6],
    output int lo_len [6],
    output int rises [6]
);
    timeunit 1ns;
    timeprecision 1ps;
    int run [6];
    logic [5:0] last;
    // sampled on the falling edge, away from the output register update
    always @(negedge hclk) begin
        for (int i = 0; i < 6; i++) begin
            if (!hresetn || pwm_in[i] === last[i]) begin
                run[i]++;
            end else begin
                if (last[i] === 1'b1) begin
                    hi_len[i] = run[i];
                end else if (last[i] === 1'b0) begin
                    lo_len[i] = run[i];
                end
                if (pwm_in[i] === 1'b1) begin
                    rises[i]++;
                end
                run[i] = 1;
            end
        end
        last = pwm_in;
    end
endmodule : pwm_sink_model
`default_nettype wire

// File: multi_channel_pulse_width_modulator_tb_top.sv
// self-checking bench for the six-channel pulse width modulator
`include "pwm_defines.svh"
`default_nettype none
module multi_channel_pulse_width_modulator_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp;
    logic fast_tick_in, xtal_tick_in, ticks_on;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rdat;
    logic [5:0] pwm_out, held;
    int hi_len [6], lo_len [6], rises [6];
    int miscompares = 0, checks_done = 0, tcnt = 0;
    // single zero-wait slave drives bus ready
    assign hready = hreadyout;
    pwm_top dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .fast_tick_in(fast_tick_in), .xtal_tick_in(xtal_tick_in),
        .pwm_out(pwm_out));
    pwm_sink_model sink (.hclk(hclk), .hresetn(hresetn), .pwm_in(pwm_out), .hi_len(hi_len),
        .lo_len(lo_len), .rises(rises));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // counting enables: fast every 2 cycles, crystal every 5
    always @(posedge hclk) begin
        tcnt <= tcnt + 1;
        fast_tick_in <= ticks_on && (tcnt % 2 == 0);
        xtal_tick_in <= ticks_on && (tcnt % 5 == 0);
    end
    // ************************************************************
    // bus and compare tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rdat = hrdata;
    endtask : bus
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask : rd_chk
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset;
        rd_chk(12'h010, 32'h00010001);
        rd_chk(12'h014, 32'h00000000);
        rd_chk(12'h000, 32'h00000000);
        rd_chk(12'h008, 32'h00000000);
        bus(1'b1, 12'h040, 32'hFFFFFFFF);
        rd_chk(12'h040, 32'h00000000);
        chk({26'h0, pwm_out}, 32'h0);
    endtask : t_reset
    // channel 0 on the fast tick, then a stall and a freeze
    task automatic t_cont;
        bus(1'b1, 12'h010, 32'h00050003);
        bus(1'b1, 12'h014, 32'h00000001);
        rd_chk(12'h010, 32'h00050003);
        cyc(80);
        chk(hi_len[0], 6);
        chk(lo_len[0], 10);
        ticks_on <= 1'b0;
        cyc(4);
        held = pwm_out;
        cyc(20);
        chk({26'h0, pwm_out}, {26'h0, held});
        // freeze while ticks run: a period is 16 cycles, so 20 frozen cycles would show a move
        ticks_on <= 1'b1;
        cyc(12);
        ce <= 1'b0;
        cyc(1);
        held = pwm_out;
        cyc(20);
        chk({26'h0, pwm_out}, {26'h0, held});
        ce <= 1'b1;
    endtask : t_cont
    // crystal tick; channel 1 low count 0 acts as 1; channel 0 keeps running
    task automatic t_xtal;
        bus(1'b1, 12'h000, 32'h00000001);
        bus(1'b1, 12'h018, 32'h00000002);
        bus(1'b1, 12'h01C, 32'h00000001);
        cyc(200);
        chk(hi_len[1], 10);
        chk(lo_len[1], 5);
        chk(hi_len[0], 15);
        chk(lo_len[0], 25);
    endtask : t_xtal
    // channels 2 and 3 grouped, 3 inverted, applied by one update
    task automatic t_group;
        int bad;
        bad = 0;
        bus(1'b1, 12'h024, 32'h00000009);
        bus(1'b1, 12'h02C, 32'h0000000D);
        bus(1'b1, 12'h020, 32'h00020003);
        bus(1'b1, 12'h028, 32'h00020003);
        cyc(30);
        chk({30'h0, pwm_out[3:2]}, 32'h0);
        bus(1'b0, 12'h008, 32'h0);
        chk(rdat & 32'h00003F00, 32'h00000C00);
        bus(1'b1, 12'h004, 32'h0000000C);
        rd_chk(12'h004, 32'h0);
        cyc(30);
        repeat (60) @(negedge hclk) if (pwm_out[3] === pwm_out[2]) bad++;
        chk(bad, 0);
        chk(hi_len[2], 15);
        chk(lo_len[3], 15);
        bus(1'b0, 12'h008, 32'h0);
        chk(rdat & 32'h00003F00, 32'h0);
    endtask : t_group
    // channel 4 single pulse
    task automatic t_single;
        int n;
        bus(1'b1, 12'h030, 32'h00020004);
        n = rises[4];
        bus(1'b1, 12'h034, 32'h00000003);
        cyc(10);
        bus(1'b0, 12'h008, 32'h0);
        chk(rdat & 32'h10, 32'h10);
        cyc(150);
        chk(rises[4] - n, 1);
        chk(hi_len[4], 20);
        chk({31'h0, pwm_out[4]}, 32'h0);
        bus(1'b0, 12'h008, 32'h0);
        chk(rdat & 32'h10, 32'h0);
    endtask : t_single
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // main sequence
    initial begin
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        fast_tick_in = 1'b0;
        xtal_tick_in = 1'b0;
        ticks_on = 1'b1;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_cont;
        t_xtal;
        t_group;
        t_single;
        report_and_stop;
    end
    // watchdog: the whole run takes under 2000 cycles
    initial begin
        #200000;
        miscompares++;
        report_and_stop;
    end
endmodule : multi_channel_pulse_width_modulator_tb_top
bind pwm_top pwm_top_properties props (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fast_tick_in(fast_tick_in), .xtal_tick_in(xtal_tick_in),
    .pwm_out(pwm_out));
`default_nettype wire
